//--- hdl/rtcpg_pkg.sv
// Constants shared by the power gate and square-wave logic.
// Assumes a 100 MHz system clock and a 32.768 kHz oscillator pin.
`default_nettype none

package rtcpg_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_EXT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SECONDS = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int A_RATE_LSB = 0;
  localparam int RATE_W = 4;
  localparam int A_DIV_LSB = 4;
  localparam int DIV_SEL_W = 3;
  localparam int B_SQW_EN = 3;
  localparam int EXT_FIXED_32K_OUTPUT_ENABLE = 0;
  localparam int EXT_ABE = 1;
  localparam int EXT_OSC_EN = 2;
  localparam int ST_PF = 0;
  localparam int ST_ACCESS = 1;
  localparam int ST_AUX = 2;
  localparam int ST_SQW = 3;
  localparam int ST_RECOVER = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam logic [2:0] DIV_SEL_PWRUP = 3'h2;
  localparam logic [1:0] CHAIN_RESET_CODE = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 100000000;
  localparam longint RECOVERY_DELAY_MS = 20;
  localparam longint RECOVERY_CYCLES = (RECOVERY_DELAY_MS * CLK_HZ + 999) / 1000;
  localparam int DIV_STAGES = 15;

  typedef enum logic [1:0] {
    GATE_FAIL,
    GATE_RECOVER,
    GATE_OPEN
  } rtcpg_gate_t;

endpackage : rtcpg_pkg

`default_nettype wire

//--- hdl/rtcpg_sqw_if.sv
// Signals between the gate top and the divider/square-wave generator.
// Assumes both ends run on the same system clock.
`default_nettype none

interface rtcpg_sqw_if;
  logic oscTick;
  logic oscLevel;
  logic oscEnable;
  logic chainReset;
  logic [3:0] rateSel;
  logic sqwEnable;
  logic fixed32kEnable;
  logic squareWave;
  logic secondTick;

  modport gen (
    input oscTick, oscLevel, oscEnable, chainReset, rateSel, sqwEnable, fixed32kEnable,
    output squareWave, secondTick
  );
  modport ctl (
    output oscTick, oscLevel, oscEnable, chainReset, rateSel, sqwEnable, fixed32kEnable,
    input squareWave, secondTick
  );
endinterface : rtcpg_sqw_if

`default_nettype wire

//--- hdl/rtcpg_sqw_gen.sv
// Fifteen-stage divider chain and square-wave tap selection.
// Assumes oscTick is a one-cycle pulse per synchronised oscillator rise.
`default_nettype none

module rtcpg_sqw_gen #(
  parameter int STAGES = rtcpg_pkg::DIV_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control and result
  rtcpg_sqw_if.gen sq
);

  logic [STAGES-1:0] divChain;
  logic [3:0] tapIdx;
  logic tapValid;

  // ---------------------------------------------------------------
  // Tap decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] rateTap(input logic [3:0] rate);
    case (rate)
      4'h0: rateTap = 5'h00;
      4'h1: rateTap = 5'h16;
      4'h2: rateTap = 5'h17;
      default: rateTap = {1'b1, rate - 4'h2};
    endcase
  endfunction : rateTap

  assign {tapValid, tapIdx} = rateTap(sq.rateSel);

  // ---------------------------------------------------------------
  // Divider chain
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divChain <= '0;
    end else if (sq.chainReset) begin
      divChain <= '0;
    end else if (sq.oscTick && sq.oscEnable) begin
      divChain <= divChain + 1'b1;
    end
  end

  assign sq.secondTick = sq.oscTick && sq.oscEnable && !sq.chainReset && (&divChain);

  // ---------------------------------------------------------------
  // Square-wave output
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sq.squareWave <= 1'b0;
    end else if (sq.fixed32kEnable) begin
      sq.squareWave <= sq.oscLevel && sq.oscEnable;
    end else if (sq.sqwEnable && tapValid) begin
      sq.squareWave <= divChain[tapIdx];
    end else begin
      sq.squareWave <= 1'b0;
    end
  end

endmodule : rtcpg_sqw_gen

`default_nettype wire

//--- hdl/rtcpg_top.sv
// Power-fail access gate, oscillator control and square-wave select.
// Assumes an APB master on clk and asynchronous supply and oscillator pins.
`default_nettype none

module rtcpg_top #(
  parameter longint RECOVERY_CYCLES = rtcpg_pkg::RECOVERY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply and oscillator pins
  input wire logic oscClkIn,
  input wire logic power_fail_trip,
  input wire logic aux_battery_supply,
  input wire logic kickstart_in_n,
  // Output pins
  output logic square_wave_out,
  output logic squareWaveOutOe,
  output logic power_on_out_n,
  output logic powerOnOutOe
);

  localparam int RC_W = 32;
  localparam logic [RC_W-1:0] REC_LAST = RC_W'(RECOVERY_CYCLES - 1);

  rtcpg_sqw_if sq ();

  // ---------------------------------------------------------------
  // Local state
  // ---------------------------------------------------------------
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic oscPrev;
  logic oscLevel;
  logic supplyLow;
  logic auxPresent;
  logic kickLow;
  logic [7:0] ctrlA;
  logic [7:0] ctrlB;
  logic [7:0] extReg;
  logic [31:0] seconds;
  rtcpg_pkg::rtcpg_gate_t gate;
  rtcpg_pkg::rtcpg_gate_t next_gate;
  logic [RC_W-1:0] recCount;
  logic accessOpen;
  logic chainReset;
  logic oscEnable;
  logic powerUp;
  logic setupPhase;
  logic accessPhase;
  logic reqError;
  logic mapped;
  logic wrTake;
  logic [31:0] next_prdata;
  logic keep32k;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic gateShut(input logic isOpen, input logic isLow);
    gateShut = !isOpen || isLow;
  endfunction : gateShut

  function automatic logic writeHit(input logic take, input logic [7:0] addr,
      input logic [7:0] regAddr);
    writeHit = take && (addr == regAddr);
  endfunction : writeHit

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Reset looks like power fail: no early power-up, no false tick
      syncA <= 4'ha;
      syncB <= 4'ha;
    end else begin
      syncA <= {kickstart_in_n, aux_battery_supply, power_fail_trip, oscClkIn};
      syncB <= syncA;
    end
  end

  assign oscLevel = syncB[0];
  assign supplyLow = syncB[1];
  assign auxPresent = syncB[2];
  assign kickLow = !syncB[3];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oscPrev <= 1'b0;
    end else begin
      oscPrev <= oscLevel;
    end
  end

  // ---------------------------------------------------------------
  // Derived control
  // ---------------------------------------------------------------
  assign oscEnable = extReg[rtcpg_pkg::EXT_OSC_EN];
  assign chainReset = (ctrlA[rtcpg_pkg::A_DIV_LSB+2 -: 2] == rtcpg_pkg::CHAIN_RESET_CODE);
  assign accessOpen = (gate == rtcpg_pkg::GATE_OPEN);
  assign powerUp = (gate == rtcpg_pkg::GATE_FAIL) && !supplyLow;
  assign keep32k = extReg[rtcpg_pkg::EXT_FIXED_32K_OUTPUT_ENABLE] && extReg[rtcpg_pkg::EXT_ABE] && auxPresent;

  // ---------------------------------------------------------------
  // Divider and square-wave generator
  // ---------------------------------------------------------------
  assign sq.oscTick = oscLevel && !oscPrev;
  assign sq.oscLevel = oscLevel;
  assign sq.oscEnable = oscEnable;
  assign sq.chainReset = chainReset;
  assign sq.rateSel = ctrlA[rtcpg_pkg::A_RATE_LSB +: rtcpg_pkg::RATE_W];
  assign sq.sqwEnable = ctrlB[rtcpg_pkg::B_SQW_EN];
  assign sq.fixed32kEnable = extReg[rtcpg_pkg::EXT_FIXED_32K_OUTPUT_ENABLE];

  rtcpg_sqw_gen #(
    .STAGES(rtcpg_pkg::DIV_STAGES)
  ) u_gen (
    .clk(clk),
    .arst_n(arst_n),
    .sq(sq.gen)
  );

  // ---------------------------------------------------------------
  // Access gate state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_gate = gate;
    case (gate)
      rtcpg_pkg::GATE_FAIL: begin
        if (!supplyLow) begin
          if (!oscEnable) begin
            next_gate = rtcpg_pkg::GATE_OPEN;
          end else begin
            next_gate = rtcpg_pkg::GATE_RECOVER;
          end
        end
      end
      rtcpg_pkg::GATE_RECOVER: begin
        if (supplyLow) begin
          next_gate = rtcpg_pkg::GATE_FAIL;
        end else if (recCount >= REC_LAST && oscEnable && !chainReset) begin
          next_gate = rtcpg_pkg::GATE_OPEN;
        end
      end
      rtcpg_pkg::GATE_OPEN: begin
        if (supplyLow) begin
          next_gate = rtcpg_pkg::GATE_FAIL;
        end
      end
      default: begin
        next_gate = rtcpg_pkg::GATE_FAIL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate <= rtcpg_pkg::GATE_FAIL;
    end else begin
      gate <= next_gate;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      recCount <= '0;
    end else if (gate != rtcpg_pkg::GATE_RECOVER) begin
      recCount <= '0;
    end else if (recCount < REC_LAST) begin
      recCount <= recCount + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // APB request decode
  // ---------------------------------------------------------------
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = accessPhase && reqError;
  assign wrTake = accessPhase && pwrite && !reqError;

  always_comb begin
    case (paddr)
      rtcpg_pkg::ADDR_CTRL_A,
      rtcpg_pkg::ADDR_CTRL_B,
      rtcpg_pkg::ADDR_EXT,
      rtcpg_pkg::ADDR_STATUS,
      rtcpg_pkg::ADDR_SECONDS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Request error is latched in setup while the gate is shut or the address is unmapped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reqError <= 1'b0;
    end else if (setupPhase) begin
      reqError <= gateShut(accessOpen, supplyLow) || !mapped;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = '0;
    case (paddr)
      rtcpg_pkg::ADDR_CTRL_A: next_prdata = {24'h000000, ctrlA};
      rtcpg_pkg::ADDR_CTRL_B: next_prdata = {24'h000000, ctrlB};
      rtcpg_pkg::ADDR_EXT: next_prdata = {24'h000000, extReg};
      rtcpg_pkg::ADDR_STATUS: begin
        next_prdata[rtcpg_pkg::ST_PF] = supplyLow;
        next_prdata[rtcpg_pkg::ST_ACCESS] = accessOpen;
        next_prdata[rtcpg_pkg::ST_AUX] = auxPresent;
        next_prdata[rtcpg_pkg::ST_SQW] = sq.squareWave;
        next_prdata[rtcpg_pkg::ST_RECOVER] = (gate == rtcpg_pkg::GATE_RECOVER);
      end
      rtcpg_pkg::ADDR_SECONDS: next_prdata = seconds;
      default: next_prdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (setupPhase) begin
      if (gateShut(accessOpen, supplyLow) || pwrite) begin
        prdata <= '0;
      end else begin
        prdata <= next_prdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register A: rate and divider select
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlA <= rtcpg_pkg::CTRL_A_RST;
    end else if (powerUp) begin
      ctrlA[rtcpg_pkg::A_DIV_LSB +: rtcpg_pkg::DIV_SEL_W] <= rtcpg_pkg::DIV_SEL_PWRUP;
    end else if (writeHit(wrTake, paddr, rtcpg_pkg::ADDR_CTRL_A)) begin
      ctrlA <= {1'b0, pwdata[6:0]};
    end
  end

  // ---------------------------------------------------------------
  // Control register B: square-wave enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlB <= rtcpg_pkg::CTRL_B_RST;
    end else if (writeHit(wrTake, paddr, rtcpg_pkg::ADDR_CTRL_B)) begin
      ctrlB <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Extended control: 32k enable, aux enable, oscillator enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extReg <= rtcpg_pkg::EXT_RST;
    end else if (powerUp) begin
      extReg[rtcpg_pkg::EXT_FIXED_32K_OUTPUT_ENABLE] <= 1'b1;
      extReg[rtcpg_pkg::EXT_OSC_EN] <= 1'b1;
    end else if (writeHit(wrTake, paddr, rtcpg_pkg::ADDR_EXT)) begin
      extReg <= {5'h00, pwdata[2:0]};
    end
  end

  // ---------------------------------------------------------------
  // Timekeeping
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seconds <= '0;
    end else if (writeHit(wrTake, paddr, rtcpg_pkg::ADDR_SECONDS)) begin
      seconds <= pwdata;
    end else if (sq.secondTick) begin
      seconds <= seconds + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------
  // Square-wave pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      square_wave_out <= 1'b0;
      squareWaveOutOe <= 1'b0;
    end else if (supplyLow) begin
      square_wave_out <= keep32k && sq.squareWave;
      squareWaveOutOe <= keep32k;
    end else begin
      square_wave_out <= sq.squareWave;
      squareWaveOutOe <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Power-on pin: open drain, pulled low by kickstart in power fail when aux is enabled and present
  // ---------------------------------------------------------------
  assign power_on_out_n = 1'b0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      powerOnOutOe <= 1'b0;
    end else if (supplyLow) begin
      powerOnOutOe <= kickLow && extReg[rtcpg_pkg::EXT_ABE] && auxPresent;
    end else begin
      powerOnOutOe <= 1'b0;
    end
  end

endmodule : rtcpg_top

`default_nettype wire

//--- testbench/rtcpg_chk.sv
// Port assertions for the power gate top.
// Assumes a bind to rtcpg_top from the bench top file.
`default_nettype none

module rtcpg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic power_fail_trip,
  input wire logic aux_battery_supply,
  input wire logic squareWaveOutOe,
  input wire logic power_on_out_n,
  input wire logic powerOnOutOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Sequences
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence sFailHeld;
    power_fail_trip [*6];
  endsequence
  sequence sSetup;
    psel && !penable;
  endsequence

  chk_fail_refused: assert property (
    sFailHeld ##0 sSetup |=> pslverr) else $error("access not refused in power fail");
  chk_fail_rdata_zero: assert property (
    sFailHeld ##0 sSetup |=> prdata == 32'h0) else $error("read data not zero in power fail");
  chk_recov_blocked: assert property (
    sFailHeld ##1 !power_fail_trip ##0 sSetup |=> pslverr) else $error("access open too soon");
  chk_fail_float: assert property (
    (power_fail_trip && !aux_battery_supply) [*6] |-> !squareWaveOutOe)
    else $error("square pin driven in power fail");
  chk_pwr_pin_low: assert property (
    powerOnOutOe |-> !power_on_out_n && $past(power_fail_trip, 3))
    else $error("power pin driven outside power fail");
  chk_unmapped_err: assert property (
    sSetup ##0 (paddr > 8'h10) |=> pslverr) else $error("unmapped access not refused");
  chk_err_in_access: assert property (
    pslverr |-> psel && penable) else $error("error outside access phase");
  chk_zero_wait: assert property (
    sSetup |=> pready ##1 $stable(prdata)) else $error("read data not held after access");
endmodule : rtcpg_chk

`default_nettype wire

//--- testbench/rtcpg_host_model.sv
// Host bus model: APB master with one transfer task.
// Assumes the bench calls xfer just after a rising clock edge.
`default_nettype none

module rtcpg_host_model (
  // Clock
  input wire logic clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  output logic timedOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timedOut = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    timedOut <= (n >= 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : rtcpg_host_model

`default_nettype wire

//--- testbench/test_rtcpg_top.sv
// Bench for the power gate and square-wave select top.
// Assumes a fast oscillator pin: ten clocks per half period.
`default_nettype none

module test_rtcpg_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FIX32K = 32'h1 << rtcpg_pkg::EXT_FIXED_32K_OUTPUT_ENABLE;
  localparam logic [31:0] AUXEN = 32'h1 << rtcpg_pkg::EXT_ABE;
  localparam logic [31:0] OSCEN = 32'h1 << rtcpg_pkg::EXT_OSC_EN;
  localparam logic [31:0] DIVUP = 32'(rtcpg_pkg::DIV_SEL_PWRUP) << rtcpg_pkg::A_DIV_LSB;
  localparam logic [31:0] WAVEON = 32'h1 << rtcpg_pkg::B_SQW_EN;
  localparam logic [31:0] STIDLE = (32'h1 << rtcpg_pkg::ST_ACCESS) |
    (32'h1 << rtcpg_pkg::ST_AUX);
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, oscClkIn, hostTimeout, err;
  logic power_fail_trip, aux_battery_supply, kickstart_in_n, square_wave_out;
  logic squareWaveOutOe, power_on_out_n, powerOnOutOe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_fail, n_checks, oscCnt, toggles;
  int rates[4] = '{0, 3, 4, 6};

  rtcpg_top #(.RECOVERY_CYCLES(20)) uut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .oscClkIn, .power_fail_trip, .aux_battery_supply,
    .kickstart_in_n, .square_wave_out, .squareWaveOutOe, .power_on_out_n, .powerOnOutOe);
  rtcpg_host_model host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timedOut(hostTimeout));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    oscCnt <= (oscCnt == 9) ? 0 : oscCnt + 1;
    if (oscCnt == 9) begin
      oscClkIn <= ~oscClkIn;
    end
  end
  always @(posedge hostTimeout) begin
    n_fail++;
    final_report();
  end

  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    host.xfer(1'b1, a, d, rd, err);
    check("write err", {31'h0, e}, {31'h0, err});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic e);
    host.xfer(1'b0, a, 32'h0, rd, err);
    check("read err", {31'h0, e}, {31'h0, err});
    check("read data", d, rd);
  endtask : rdc

  task automatic pin_oe(input logic e, input logic p);
    @(negedge clk);
    check("square pin enable", {31'h0, e}, {31'h0, squareWaveOutOe});
    check("power pin enable", {31'h0, p}, {31'h0, powerOnOutOe});
    @(posedge clk);
  endtask : pin_oe

  task automatic tog(input int want, input int slack);
    logic last;
    toggles = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    last = square_wave_out;
    repeat (1280) begin
      @(negedge clk);
      if (square_wave_out !== last) begin
        toggles++;
      end
      last = square_wave_out;
    end
    if (toggles >= want - slack && toggles <= want + slack) begin
      toggles = want;
    end
    check("square toggles", 32'(want), 32'(toggles));
    @(posedge clk);
  endtask : tog

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    oscClkIn = 1'b0;
    oscCnt = 0;
    power_fail_trip = 1'b0;
    aux_battery_supply = 1'b1;
    kickstart_in_n = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(rtcpg_pkg::ADDR_EXT, FIX32K | OSCEN, 1'b0);
    rdc(rtcpg_pkg::ADDR_CTRL_A, DIVUP, 1'b0);
    rdc(8'h14, 32'h0, 1'b1);
    tog(128, 2);
    $display("test power-up done");
    wr(rtcpg_pkg::ADDR_CTRL_A, DIVUP | 32'h3, 1'b0);
    tog(128, 2);
    wr(rtcpg_pkg::ADDR_EXT, OSCEN, 1'b0);
    tog(0, 0);
    rdc(rtcpg_pkg::ADDR_STATUS, STIDLE, 1'b0);
    wr(rtcpg_pkg::ADDR_CTRL_B, WAVEON, 1'b0);
    foreach (rates[i]) begin
      wr(rtcpg_pkg::ADDR_CTRL_A, DIVUP | 32'(rates[i]), 1'b0);
      tog((rates[i] == 0) ? 0 : 64 >> (rates[i] - 2), 1);
    end
    wr(rtcpg_pkg::ADDR_CTRL_B, 32'h0, 1'b0);
    wr(rtcpg_pkg::ADDR_EXT, FIX32K, 1'b0);
    tog(0, 0);
    $display("test square wave done");
    wr(rtcpg_pkg::ADDR_SECONDS, 32'h00001234, 1'b0);
    wr(rtcpg_pkg::ADDR_EXT, FIX32K | AUXEN | OSCEN, 1'b0);
    power_fail_trip <= 1'b1;
    repeat (6) @(posedge clk);
    wr(rtcpg_pkg::ADDR_CTRL_B, WAVEON, 1'b1);
    rdc(rtcpg_pkg::ADDR_EXT, 32'h0, 1'b1);
    tog(128, 2);
    pin_oe(1'b1, 1'b0);
    kickstart_in_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_oe(1'b1, 1'b1);
    kickstart_in_n <= 1'b1;
    aux_battery_supply <= 1'b0;
    repeat (6) @(posedge clk);
    pin_oe(1'b0, 1'b0);
    power_fail_trip <= 1'b0;
    rdc(rtcpg_pkg::ADDR_CTRL_B, 32'h0, 1'b1);
    repeat (25) @(posedge clk);
    rdc(rtcpg_pkg::ADDR_CTRL_B, 32'h0, 1'b0);
    rdc(rtcpg_pkg::ADDR_SECONDS, 32'h00001234, 1'b0);
    $display("test power fail done");
    wr(rtcpg_pkg::ADDR_EXT, 32'h0, 1'b0);
    power_fail_trip <= 1'b1;
    repeat (6) @(posedge clk);
    power_fail_trip <= 1'b0;
    repeat (5) @(posedge clk);
    rdc(rtcpg_pkg::ADDR_EXT, FIX32K | OSCEN, 1'b0);
    $display("test stopped oscillator done");
    final_report();
  end
endmodule : test_rtcpg_top

bind rtcpg_top rtcpg_chk chk (.clk, .arst_n, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .power_fail_trip, .aux_battery_supply, .squareWaveOutOe, .power_on_out_n,
  .powerOnOutOe);

`default_nettype wire
